// ===== rtl/dbrk_pkg.sv
// Package with register map, field positions and reset values of the debug break block
// Notes on behaviour
// - Comparator 1 full match breaks on 24 bits
// - Comparator 1 ignore-low compares bits 23..8
// - Comparator 0 full match breaks on 24 bits
// - Comparator 0 ignore-low compares bits 23..8
// - Break control bits 2,1,0: ignore-lows, single-step
// - Single-step breaks after every completed instruction
// - Master bit 7 starts reset, held until cpu_reset_done
// - Master control at 11h, resets zero
// - Master control wakes from halt and sleep
// - Staging bytes 13h,14h,15h form write operand
// - Per-comparator enable gates its break
// - Breaks only land on instruction boundaries
// - Breaks set break-next; host clears to release
// - Command write executes at once with operand
package dbrk_pkg;
  localparam logic [6:0] OFS_CMP0_LOW      = 7'h00;
  localparam logic [6:0] OFS_CMP0_HIGH     = 7'h01;
  localparam logic [6:0] OFS_CMP0_UPPER    = 7'h02;
  localparam logic [6:0] OFS_CMP1_LOW      = 7'h04;
  localparam logic [6:0] OFS_CMP1_HIGH     = 7'h05;
  localparam logic [6:0] OFS_CMP1_UPPER    = 7'h06;
  localparam logic [6:0] OFS_BREAK_CONTROL = 7'h10;
  localparam logic [6:0] OFS_MASTER_CTL    = 7'h11;
  localparam logic [6:0] OFS_WR_UPPER      = 7'h13;
  localparam logic [6:0] OFS_WR_HIGH       = 7'h14;
  localparam logic [6:0] OFS_WR_LOW        = 7'h15;
  localparam logic [6:0] OFS_ACCESS_CMD    = 7'h16;

  localparam int BIT_BRK_NEXT    = 7;
  localparam int BIT_CMP1_EN     = 4;
  localparam int BIT_CMP0_EN     = 3;
  localparam int BIT_IGN_LOW_1   = 2;
  localparam int BIT_IGN_LOW_0   = 1;
  localparam int BIT_SINGLE_STEP = 0;
  localparam int BIT_FORCE_RESET = 7;
  localparam int BIT_CMD_WRITE   = 7;

  localparam logic [7:0]  BREAK_CONTROL_RESET = 8'h00;
  localparam logic [7:0]  MASTER_CTL_RESET    = 8'h00;
  localparam logic [23:0] OPERAND_RESET       = 24'h000000;
  localparam logic [23:0] CMP_RESET           = 24'h000000;
endpackage : dbrk_pkg

// ===== rtl/dbrk_addr_cmp.sv
// Address comparator with optional low-byte masking
`timescale 1ns/10ps
module dbrk_addr_cmp (
  input  wire logic [23:0] instr_addr,
  input  wire logic [23:0] match_value,
  input  wire logic        ignore_low,
  output logic             hit
);
  always_comb begin
    if (ignore_low) begin
      hit = (instr_addr[23:8] == match_value[23:8]);
    end else begin
      hit = (instr_addr == match_value);
    end
  end
endmodule : dbrk_addr_cmp

// ===== rtl/dbrk_core.sv
// Debug break control, master control and write-operand staging
`timescale 1ns/10ps
module dbrk_core
  import dbrk_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        link_clk,
  input  wire logic        link_rst_n,
  input  wire logic        link_wr,
  input  wire logic [6:0]  link_addr,
  input  wire logic [7:0]  link_data,
  output logic             link_busy,
  input  wire logic [23:0] instr_addr,
  input  wire logic        instr_start,
  input  wire logic        instr_done,
  input  wire logic        cpu_reset_done,
  output logic             cpu_break,
  output logic             force_cpu_reset,
  output logic             cpu_wake,
  output logic             cmd_valid,
  output logic [7:0]       cmd_code,
  output logic             cmd_is_write,
  output logic [23:0]      cmd_operand
);

  // Link-side state: one held write plus the returning acknowledge
  typedef struct packed {
    logic       req_tgl;
    logic [6:0] addr;
    logic [7:0] data;
    logic       ack_s1;
    logic       ack_s2;
  } dbrk_link_t;

  // Core-side state
  typedef struct packed {
    logic        req_s1;
    logic        req_s2;
    logic        req_seen;
    logic [7:0]  brk_ctl;
    logic [23:0] cmp0;
    logic [23:0] cmp1;
    logic [23:0] wr_op;
    logic        reset_busy;
    logic        match_pend;
    logic        wake;
    logic        cmd_valid;
    logic [7:0]  cmd_code;
  } dbrk_core_t;

  dbrk_link_t lk;
  dbrk_link_t next_lk;
  dbrk_core_t cs;
  dbrk_core_t next_cs;

  logic hit0;
  logic hit1;
  logic wr_now;
  logic brk_set;

  // Link domain: a write is held until the core echoes the toggle back
  always_comb begin
    next_lk        = lk;
    next_lk.ack_s1 = cs.req_seen;
    next_lk.ack_s2 = lk.ack_s1;
    if (link_wr && (lk.req_tgl == lk.ack_s2)) begin
      next_lk.addr    = link_addr;
      next_lk.data    = link_data;
      next_lk.req_tgl = ~lk.req_tgl;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  assign link_busy = (lk.req_tgl != lk.ack_s2);

  dbrk_addr_cmp u_cmp0 (
    .instr_addr  (instr_addr),
    .match_value (cs.cmp0),
    .ignore_low  (cs.brk_ctl[BIT_IGN_LOW_0]),
    .hit         (hit0)
  );

  dbrk_addr_cmp u_cmp1 (
    .instr_addr  (instr_addr),
    .match_value (cs.cmp1),
    .ignore_low  (cs.brk_ctl[BIT_IGN_LOW_1]),
    .hit         (hit1)
  );

  always_comb begin
    next_cs           = cs;
    next_cs.req_s1    = lk.req_tgl;
    next_cs.req_s2    = cs.req_s1;
    next_cs.req_seen  = cs.req_s2;
    next_cs.wake      = 1'b0;
    next_cs.cmd_valid = 1'b0;
    wr_now            = (cs.req_s2 != cs.req_seen);

    // Matches are only noted at the first opcode, the break waits for the end
    if (instr_start && ((hit0 && cs.brk_ctl[BIT_CMP0_EN]) ||
                        (hit1 && cs.brk_ctl[BIT_CMP1_EN]))) begin
      next_cs.match_pend = 1'b1;
    end
    brk_set = instr_done && (cs.match_pend || cs.brk_ctl[BIT_SINGLE_STEP]);
    if (instr_done) begin
      next_cs.match_pend = 1'b0;
    end

    if (cpu_reset_done) begin
      next_cs.reset_busy = 1'b0;
    end

    // Held link word is stable while the toggle is outstanding
    if (wr_now) begin
      case (lk.addr)
        OFS_CMP0_LOW:      next_cs.cmp0[7:0]   = lk.data;
        OFS_CMP0_HIGH:     next_cs.cmp0[15:8]  = lk.data;
        OFS_CMP0_UPPER:    next_cs.cmp0[23:16] = lk.data;
        OFS_CMP1_LOW:      next_cs.cmp1[7:0]   = lk.data;
        OFS_CMP1_HIGH:     next_cs.cmp1[15:8]  = lk.data;
        OFS_CMP1_UPPER:    next_cs.cmp1[23:16] = lk.data;
        OFS_BREAK_CONTROL: next_cs.brk_ctl     = lk.data;
        OFS_MASTER_CTL: begin
          next_cs.wake = 1'b1;
          if (lk.data[BIT_FORCE_RESET]) begin
            next_cs.reset_busy = 1'b1;
          end
        end
        OFS_WR_UPPER:      next_cs.wr_op[23:16] = lk.data;
        OFS_WR_HIGH:       next_cs.wr_op[15:8]  = lk.data;
        OFS_WR_LOW:        next_cs.wr_op[7:0]   = lk.data;
        OFS_ACCESS_CMD: begin
          next_cs.cmd_valid = 1'b1;
          next_cs.cmd_code  = lk.data;
        end
        default: begin
        end
      endcase
    end

    // A break event wins over a host clear in the same cycle
    if (brk_set) begin
      next_cs.brk_ctl[BIT_BRK_NEXT] = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cs            <= '0;
      cs.brk_ctl    <= BREAK_CONTROL_RESET;
      cs.reset_busy <= MASTER_CTL_RESET[BIT_FORCE_RESET];
      cs.wr_op      <= OPERAND_RESET;
      cs.cmp0       <= CMP_RESET;
      cs.cmp1       <= CMP_RESET;
    end else begin
      cs <= next_cs;
    end
  end

  assign cpu_break       = cs.brk_ctl[BIT_BRK_NEXT];
  assign force_cpu_reset = cs.reset_busy;
  assign cpu_wake        = cs.wake;
  assign cmd_valid       = cs.cmd_valid;
  assign cmd_code        = cs.cmd_code;
  assign cmd_is_write    = cs.cmd_code[BIT_CMD_WRITE];
  assign cmd_operand     = cs.wr_op;

endmodule : dbrk_core

// ===== verification/dbrk_core_props.sv
// Checker of break, reset and command outputs
`timescale 1ns/10ps
module dbrk_core_props (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        link_busy,
  input wire logic        instr_done,
  input wire logic        cpu_reset_done,
  input wire logic        cpu_break,
  input wire logic        force_cpu_reset,
  input wire logic        cpu_wake,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_code,
  input wire logic        cmd_is_write,
  input wire logic [23:0] cmd_operand
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_rst_holds: assert property (force_cpu_reset && !cpu_reset_done |=> force_cpu_reset)
    else $error("reset dropped early");
  a_rst_clears: assert property ($fell(force_cpu_reset) |-> $past(cpu_reset_done))
    else $error("reset cleared without done");
  a_wake_pulse: assert property (cpu_wake |=> !cpu_wake)
    else $error("wake too long");
  a_break_on_done: assert property ($rose(cpu_break) && !$past(link_busy) |-> $past(instr_done))
    else $error("break off boundary");
  a_break_holds: assert property (cpu_break && !link_busy |=> cpu_break)
    else $error("break lost");
  a_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
    else $error("command pulse too long");
  a_cmd_kind: assert property (cmd_valid |-> cmd_is_write == cmd_code[7])
    else $error("command kind wrong");
  a_operand_holds: assert property (!$past(link_busy) |-> $stable(cmd_operand) && $stable(cmd_code))
    else $error("operand changed");
  cover property (cmd_valid && cmd_is_write);
  cover property ($rose(cpu_break));
  cover property ($fell(force_cpu_reset));
endmodule : dbrk_core_props
bind dbrk_core dbrk_core_props u_props (.*);

// ===== verification/dbrk_host.sv
// Debug host model writing link registers
`timescale 1ns/10ps
module dbrk_host (
  input  wire logic       link_clk,
  input  wire logic       link_busy,
  output logic            link_wr = 1'b0,
  output logic [6:0]      link_addr = '0,
  output logic [7:0]      link_data = '0
);
  // Strobe held until taken; next write only once busy has dropped
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge link_clk);
    link_wr <= 1'b1;
    link_addr <= a;
    link_data <= d;
    do @(posedge link_clk); while (link_busy);
    link_wr <= 1'b0;
    link_data <= ~d;
    for (int i = 0; i < 99 && (i < 3 || link_busy); i++) @(posedge link_clk);
  endtask : wr
endmodule : dbrk_host

// ===== verification/tb_dbrk_core.sv
// Bench for the debug break block
`timescale 1ns/10ps
module tb_dbrk_core;
  import dbrk_pkg::*;
  logic mclk = 0, link_clk = 0, rst_n = 0, instr_start = 0, instr_done = 0, cpu_reset_done = 0;
  logic [23:0] instr_addr = '0, cmd_operand;
  logic link_wr, link_busy, cpu_break, force_cpu_reset, cpu_wake, cmd_valid, cmd_is_write;
  logic [6:0] link_addr;
  logic [7:0] link_data, cmd_code;
  wire logic link_rst_n = rst_n;
  int n_errors = 0, checked = 0, n_cmd = 0, n_wake = 0;
  dbrk_core u_dut (.*);
  dbrk_host u_host (.*);
  initial forever #50 mclk = ~mclk;
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  always @(posedge mclk) begin
    if (cmd_valid) n_cmd++;
    if (cpu_wake) n_wake++;
  end
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic t_stage();
    u_host.wr(OFS_WR_UPPER, 8'hA5);
    u_host.wr(OFS_WR_HIGH, 8'h3C);
    u_host.wr(OFS_WR_LOW, 8'h0F);
    u_host.wr(OFS_ACCESS_CMD, 8'h80);
    // The pulse is counted at the mclk edge after the register update
    @(posedge mclk) #1;
    chk("pulses", 24'd1, 24'(n_cmd));
    chk("write kind", 24'h1, 24'(cmd_is_write));
    chk("code", 24'h80, 24'(cmd_code));
    chk("operand", 24'hA53C0F, cmd_operand);
    u_host.wr(OFS_WR_LOW, 8'hC3);
    u_host.wr(OFS_ACCESS_CMD, 8'h07);
    chk("kind", 24'h0, 24'(cmd_is_write));
    chk("reused", 24'hA53CC3, cmd_operand);
    $display("stage test done");
  endtask : t_stage
  task automatic t_master();
    u_host.wr(7'h12, 8'h80);
    u_host.wr(OFS_MASTER_CTL, 8'h00);
    chk("no reset", 24'h0, 24'(force_cpu_reset));
    u_host.wr(OFS_MASTER_CTL, 8'h80);
    chk("reset set", 24'h1, 24'(force_cpu_reset));
    @(posedge mclk) #1;
    chk("wakes", 24'd2, 24'(n_wake));
    @(posedge mclk) cpu_reset_done <= 1'b1;
    @(posedge mclk) cpu_reset_done <= 1'b0;
    @(posedge mclk) #1 chk("reset end", 24'h0, 24'(force_cpu_reset));
    $display("master test done");
  endtask : t_master
  task automatic t_breaks();
    logic [31:0] tbl [8] = '{32'h08123456, 32'h081234AB, 32'h0A1234AB, 32'h00123456,
                             32'h10ABCDEF, 32'h10ABCD00, 32'h14ABCD00, 32'h01000777};
    logic [0:7] hit = 8'b10101011;
    for (int j = 0; j < 3; j++) begin
      u_host.wr(OFS_CMP0_LOW + 7'(j), 8'(24'h123456 >> (8 * j)));
      u_host.wr(OFS_CMP1_LOW + 7'(j), 8'(24'hABCDEF >> (8 * j)));
    end
    for (int i = 0; i < 8; i++) begin
      u_host.wr(OFS_BREAK_CONTROL, tbl[i][31:24]);
      chk("released", 24'h0, 24'(cpu_break));
      @(posedge mclk) instr_addr <= tbl[i][23:0];
      instr_start <= 1'b1;
      @(posedge mclk) instr_start <= 1'b0;
      @(posedge mclk) #1 chk("mid", 24'h0, 24'(cpu_break));
      @(posedge mclk) instr_done <= 1'b1;
      @(posedge mclk) instr_done <= 1'b0;
      @(posedge mclk) #1 chk("brk", 24'(hit[i]), 24'(cpu_break));
    end
    $display("break test done");
  endtask : t_breaks
  task automatic test_done();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    t_stage();
    t_master();
    t_breaks();
    test_done();
  end
  initial begin
    #1ms;
    n_errors++;
    test_done();
  end
endmodule : tb_dbrk_core
